/* File: dv/tb_top.sv */
/*
  self-checking bench for the decrement-and-skip block.
  assumes the package and design module are compiled before it.
*/
module tb_top
  import decrement_skip_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] instr_word = 16'h0000;
  logic        instr_valid = 1'b0;
  logic        instr_two_word = 1'b0;
  logic [3:0]  bank_select_value = 4'h0;
  logic [7:0]  salt = 8'h00;
  logic [11:0] mem_addr;
  logic [7:0]  mem_rdata;
  logic        mem_we;
  logic [7:0]  mem_wdata;
  logic [7:0]  wreg;
  logic        skipping;
  logic        status_we;
  logic [7:0]  exp_wreg = 8'h00;
  logic [31:0] seed = 32'h3A2ACEE9;
  logic [31:0] r;
  int          failures = 0;
  int          n_tests = 0;
  // ----------------------------------------
  // clock, memory stand-in, design
  // ----------------------------------------
  always #50 clock = ~clock;
  function automatic logic [7:0] rd(logic [11:0] ad, logic [7:0] s);
    return ad[7:0] ^ {ad[11:8], ad[11:8]} ^ s;
  endfunction
  assign mem_rdata = rd(mem_addr, salt);
  decrement_skip_exec dut (.clock, .rst, .instr_word, .instr_valid,
    .instr_two_word, .bank_select_value, .mem_addr, .mem_rdata,
    .mem_we, .mem_wdata, .wreg, .skipping, .status_we);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [11:0] ea(logic a, logic [7:0] f, logic [3:0] b);
    if (a)
      return {b, f};
    return {(f < ACCESS_SPLIT) ? ACCESS_BANK_LOW : ACCESS_BANK_HIGH, f};
  endfunction
  task automatic chk(logic [11:0] got, logic [11:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one instruction, its follower words, then idle
  task automatic run(logic nz, logic d, logic a, logic [7:0] f,
                     logic [3:0] b, logic two, logic z);
    logic [11:0] ad;
    logic [7:0]  s;
    logic [7:0]  res;
    logic        sk;
    ad = ea(a, f, b);
    s = z ? rd(ad, 8'h01) : 8'(rnd());
    res = rd(ad, s) - 8'h01;
    sk = nz ? (res != 8'h00) : (res == 8'h00);
    @(posedge clock);
    instr_word <= {nz ? OPC_DEC_SKIP_NONZERO : OPC_DEC_SKIP_ZERO, d, a, f};
    instr_valid <= 1'b1;
    bank_select_value <= b;
    salt <= s;
    @(negedge clock);
    chk(mem_addr, ad);
    chk(mem_we, d);
    chk(mem_wdata, res);
    chk(status_we, 1'b0);
    if (!d)
      exp_wreg = res;
    @(posedge clock);
    instr_word <= sk ? {OPC_DEC_SKIP_ZERO, 2'b11, f} : 16'h0000;
    instr_two_word <= two;
    @(negedge clock);
    chk(skipping, sk);
    chk(wreg, exp_wreg);
    chk(mem_we, 1'b0);
    if (two)
    begin
      @(posedge clock);
      instr_two_word <= 1'b0;
      @(negedge clock);
      chk(skipping, sk);
      chk(mem_we, 1'b0);
    end
    @(posedge clock);
    instr_valid <= 1'b0;
    instr_two_word <= 1'b0;
    @(negedge clock);
    chk(skipping, 1'b0);
    chk(wreg, exp_wreg);
  endtask
  // ----------------------------------------
  // sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge clock);
    chk(wreg, 8'h00);
    chk(skipping, 1'b0);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++)
      run(i[0], i[1], i[2], i[3] ? 8'h80 : 8'h7F, 4'h5, i[3], 1'b1);
    for (int i = 0; i < 200; i++)
    begin
      r = rnd();
      run(r[0], r[1], r[2], r[15:8], r[19:16], r[3], r[4] & r[5]);
    end
    complete_run();
  end
  initial
  begin
    #500000;
    failures++;
    complete_run();
  end
endmodule

/* File: rtl/decrement_skip_exec.sv */
/*
  execution of the two decrement-and-skip instructions.
  assumes the fetch unit presents one instruction word per cycle
  with a flag telling whether it opens a two-word instruction,
  and that data memory reads combinationally.
*/
module decrement_skip_exec
  import decrement_skip_pkg::*;
#(
  parameter int DATA_WIDTH = 8
)
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // instruction stream
  input  wire logic [15:0]           instr_word,
  input  wire logic                  instr_valid,
  input  wire logic                  instr_two_word,
  input  wire logic [3:0]            bank_select_value,
  // data memory
  output logic [11:0]                mem_addr,
  input  wire logic [DATA_WIDTH-1:0] mem_rdata,
  output logic                       mem_we,
  output logic [DATA_WIDTH-1:0]      mem_wdata,
  // accumulator, skip flag and status
  output logic [DATA_WIDTH-1:0]      wreg,
  output logic                       skipping,
  output logic                       status_we
);
  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (DATA_WIDTH != 8)
  begin : g_bad_width
    $error("DATA_WIDTH must be 8");
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic is_op(input logic [15:0] w,
                                 input logic [5:0] opc);
    is_op = (w[OPC_MSB:OPC_LSB] == opc);
  endfunction

  logic                  op_zero;
  logic                  op_nonzero;
  logic                  exec_ok;
  logic [DATA_WIDTH-1:0] result;
  logic                  take_skip;

  assign op_zero    = is_op(instr_word, OPC_DEC_SKIP_ZERO);
  assign op_nonzero = is_op(instr_word, OPC_DEC_SKIP_NONZERO);

  exec_state_type state_reg;
  exec_state_type state_next;
  logic [1:0]     skip_cnt_reg;
  logic [1:0]     skip_cnt_next;
  logic [DATA_WIDTH-1:0] wreg_reg;
  logic [DATA_WIDTH-1:0] wreg_next;

  assign exec_ok = instr_valid && (state_reg == EXEC_RUN);

  // ----------------------------------------------------------------
  // operand address and result
  // ----------------------------------------------------------------
  always_comb
  begin
    if (!instr_word[BANK_ACCESS_BIT])
      mem_addr = {(instr_word[7:0] < ACCESS_SPLIT) ? ACCESS_BANK_LOW
                                                   : ACCESS_BANK_HIGH,
                  instr_word[7:0]};
    else
      mem_addr = {bank_select_value, instr_word[7:0]};
  end

  assign result    = mem_rdata - 8'h01;
  assign mem_wdata = result;
  assign mem_we    = exec_ok && (op_zero || op_nonzero)
                     && instr_word[DEST_BIT];
  assign status_we = 1'b0;

  assign take_skip = exec_ok && ((op_zero && result == 8'h00)
                     || (op_nonzero && result != 8'h00));

  // ----------------------------------------------------------------
  // skip sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next    = state_reg;
    skip_cnt_next = skip_cnt_reg;
    wreg_next     = wreg_reg;
    if (exec_ok && (op_zero || op_nonzero) && !instr_word[DEST_BIT])
      wreg_next = result;
    unique case (state_reg)
      EXEC_RUN:
      begin
        if (take_skip)
        begin
          state_next    = EXEC_SKIP;
          skip_cnt_next = 2'h0;
        end
      end
      EXEC_SKIP:
      begin
        if (instr_valid && instr_two_word && skip_cnt_reg == 2'h0)
          skip_cnt_next = 2'h1;
        else if (instr_valid)
          state_next = EXEC_RUN;
      end
      default:
        state_next = EXEC_RUN;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg    <= EXEC_RUN;
      skip_cnt_reg <= 2'h0;
      wreg_reg     <= WREG_RESET;
    end
    else
    begin
      state_reg    <= state_next;
      skip_cnt_reg <= skip_cnt_next;
      wreg_reg     <= wreg_next;
    end
  end

  assign wreg     = wreg_reg;
  assign skipping = (state_reg == EXEC_SKIP);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_wreg_dest;
    @(posedge clock) disable iff (rst)
      (exec_ok && (op_zero || op_nonzero) && !instr_word[DEST_BIT])
      |=> (wreg == $past(mem_rdata) - 8'h01);
  endproperty
  a_wreg_dest: assert property (p_wreg_dest)
    else $error("accumulator not loaded with decrement");

  property p_no_mem_write_w;
    @(posedge clock) disable iff (rst)
      !instr_word[DEST_BIT] |-> !mem_we;
  endproperty
  a_no_mem_write_w: assert property (p_no_mem_write_w)
    else $error("register written with d clear");

  property p_write_back;
    @(posedge clock) disable iff (rst)
      (exec_ok && (op_zero || op_nonzero) && instr_word[DEST_BIT])
      |-> mem_we && (mem_wdata == mem_rdata - 8'h01);
  endproperty
  a_write_back: assert property (p_write_back)
    else $error("register not written with decrement");

  property p_zero_skip;
    @(posedge clock) disable iff (rst)
      (exec_ok && op_zero && mem_rdata == 8'h01) |=> skipping;
  endproperty
  a_zero_skip: assert property (p_zero_skip)
    else $error("zero result did not skip");

  property p_zero_no_skip;
    @(posedge clock) disable iff (rst)
      (exec_ok && op_zero && mem_rdata != 8'h01) |=> !skipping;
  endproperty
  a_zero_no_skip: assert property (p_zero_no_skip)
    else $error("zero skip taken on nonzero result");

  property p_nonzero_skip;
    @(posedge clock) disable iff (rst)
      (exec_ok && op_nonzero && mem_rdata == 8'h01) |=> !skipping;
  endproperty
  a_nonzero_skip: assert property (p_nonzero_skip)
    else $error("nonzero skip taken on zero result");

  property p_nonzero_taken;
    @(posedge clock) disable iff (rst)
      (exec_ok && op_nonzero && mem_rdata != 8'h01) |=> skipping;
  endproperty
  a_nonzero_taken: assert property (p_nonzero_taken)
    else $error("nonzero result did not skip");

  property p_access_bank;
    @(posedge clock) disable iff (rst)
      instr_word[BANK_ACCESS_BIT] |-> mem_addr[11:8] == bank_select_value;
  endproperty
  a_access_bank: assert property (p_access_bank)
    else $error("bank select not used");

  property p_access_low;
    @(posedge clock) disable iff (rst)
      (!instr_word[BANK_ACCESS_BIT] && instr_word[7:0] < ACCESS_SPLIT)
      |-> mem_addr == {ACCESS_BANK_LOW, instr_word[7:0]};
  endproperty
  a_access_low: assert property (p_access_low)
    else $error("access bank not used");

  property p_two_word;
    @(posedge clock) disable iff (rst)
      (skipping && instr_valid && instr_two_word && skip_cnt_reg == 2'h0)
      |=> skipping;
  endproperty
  a_two_word: assert property (p_two_word)
    else $error("two-word skip ended early");

  property p_skip_ends;
    @(posedge clock) disable iff (rst)
      (skipping && instr_valid && !instr_two_word) |=> !skipping;
  endproperty
  a_skip_ends: assert property (p_skip_ends)
    else $error("skip lasted too long");

  property p_no_write_in_skip;
    @(posedge clock) disable iff (rst)
      skipping |-> !mem_we ##1 $stable(wreg);
  endproperty
  a_no_write_in_skip: assert property (p_no_write_in_skip)
    else $error("skipped word had effect");

  c_zero_skip: cover property (@(posedge clock) op_zero && take_skip);
  c_nz_skip:   cover property (@(posedge clock) op_nonzero && take_skip);
  c_two_word:  cover property (@(posedge clock)
                 skipping && instr_valid && instr_two_word);
endmodule

/* File: rtl/decrement_skip_pkg.sv */
/*
  constants and types for the decrement-and-skip execution block.
  assumes one instruction clock and an external data memory port.
*/
// Contract
// - decrement register, d picks accumulator or register
// - zero result skips next word as no-op
// - nonzero result skips next word as no-op
// - a=0 access bank, a=1 bank-select value
// - skipped two-word instruction costs two no-ops
package decrement_skip_pkg;
  localparam logic [5:0] OPC_DEC_SKIP_ZERO    = 6'h0B;
  localparam logic [5:0] OPC_DEC_SKIP_NONZERO = 6'h13;
  localparam int         OPC_MSB              = 15;
  localparam int         OPC_LSB              = 10;
  localparam int         DEST_BIT             = 9;
  localparam int         BANK_ACCESS_BIT      = 8;
  localparam logic [3:0] ACCESS_BANK_LOW      = 4'h0;
  localparam logic [3:0] ACCESS_BANK_HIGH     = 4'hF;
  localparam logic [7:0] ACCESS_SPLIT         = 8'h80;
  localparam logic [7:0] WREG_RESET           = 8'h00;
  localparam logic [3:0] BANK_RESET           = 4'h0;

  typedef enum logic [1:0]
  {
    EXEC_RUN  = 2'b00,
    EXEC_SKIP = 2'b01
  } exec_state_type;
endpackage
